// file: hdl/card_pkg.sv
// card_pkg: constants, types and carriers for the card signal block.
// assumes one 10 MHz pclk domain and host pins already synchronous to it.
package card_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100; // pclk period
  localparam int unsigned INIT_TIME_US = 100; // initialisation time
  localparam int unsigned PULSE_TIME_NS = 300; // least irq pulse width
  localparam int unsigned PULSE_CYC =
    (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // rounded up
  localparam int unsigned ADDR_W = 8; // apb address width
  localparam logic [7:0] OFS_CTRL = 8'h00; // control register
  localparam logic [7:0] OFS_STAT = 8'h04; // status register
  localparam int unsigned CTRL_IO = 0; // i/o mode selected by config
  localparam int unsigned CTRL_LVL = 1; // level rather than pulse irq
  localparam int unsigned CTRL_DMA = 2; // dma mode enabled
  localparam logic [2:0] CTRL_RST = 3'h0; // control after reset
  localparam int unsigned STAT_READY = 0; // card ready, not busy
  localparam int unsigned STAT_IDE = 1; // latched ide mode
  localparam int unsigned STAT_IRQ = 2; // interrupt pending, w1c
  localparam int unsigned STAT_INIT = 3; // initialisation done
  localparam int unsigned STAT_HOLD = 4; // held in reset since power-up
  typedef enum logic [2:0] {
    ST_RESET = 3'b001, // host reset active or mode being latched
    ST_INIT = 3'b010, // internal initialisation running
    ST_READY = 3'b100 // normal operation
  } card_st_t;
  typedef struct packed {
    logic mode_sel; // mode pin: high pc card, low ide
    logic rst_pin; // host reset pin level
    logic rst_open; // reset pin left unconnected
    logic reg_n; // register select, low for attribute
    logic dmack_n; // dma acknowledge, active low
    logic we_n; // write strobe, active low
  } host_pins_t;
  typedef struct packed {
    logic busy; // card core busy
    logic irq_evt; // one-cycle interrupt event
    logic port16; // addressed port is 16-bit capable
    logic word_xfer; // current ide cycle is word wide
  } core_stat_t;
  typedef struct packed {
    logic rdy_irq; // ready / -ireq / intrq shared pin
    logic wait_n; // -wait / iordy pin
    logic wp; // wp / -iois16 / -iocs16 shared pin
  } card_pins_t;
  typedef struct packed {
    logic attr_sel; // attribute space selected
    logic mem_wr; // memory write strobe pulse
    logic cfg_wr; // configuration write strobe pulse
    logic dmack; // qualified dma acknowledge
    logic init_done; // initialisation finished
  } core_ctl_t;
endpackage

// file: hdl/cnt_timer.sv
// cnt_timer: retriggerable down counter giving a busy window.
// assumes start is a synchronous one-cycle request in the pclk domain.
`timescale 1ns/10ps
`default_nettype none
module cnt_timer #(
  parameter int unsigned CYCLES = 4, // busy length in cycles
  parameter int unsigned W = $clog2(CYCLES + 1) // counter width
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic start, // load and start
  output logic busy // high exactly CYCLES cycles after start
);
  localparam logic [W-1:0] LOAD = W'(CYCLES); // reload value
  logic [W-1:0] cnt_r; // remaining cycles

  // reload wins over the running count so a retrigger restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      busy <= 1'b0;
    end else if (start) begin
      cnt_r <= LOAD;
      busy <= 1'b1;
    end else if (cnt_r > W'(1)) begin
      cnt_r <= cnt_r - W'(1);
    end else begin
      cnt_r <= '0;
      busy <= 1'b0;
    end
  end
endmodule // cnt_timer
`default_nettype wire

// file: hdl/card_host_signal_control.sv
// card_host_signal_control: control pins of a removable card connector.
// assumes host pins synchronous to pclk and an apb master for software.
`timescale 1ns/10ps
`default_nettype none
module card_host_signal_control #(
  parameter int unsigned INIT_TIME_US = card_pkg::INIT_TIME_US // init
) (
  input wire logic pclk, // apb clock, 10 MHz
  input wire logic presetn, // power-up reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire card_pkg::host_pins_t host, // host side pins
  input wire card_pkg::core_stat_t core, // card core status
  output card_pkg::card_pins_t pins, // card output pins
  output card_pkg::core_ctl_t ctl // strobes to card core
);
  // init time in cycles, rounded up and never below one
  localparam int unsigned INIT_RAW =
    (INIT_TIME_US * 1000 + card_pkg::CLK_PERIOD_NS - 1)
    / card_pkg::CLK_PERIOD_NS;
  localparam int unsigned INIT_CYC = (INIT_RAW < 1) ? 1 : INIT_RAW;

  card_pkg::card_st_t st_r; // reset/init/ready state
  card_pkg::card_st_t st_nxt; // next state
  logic first_r; // still in the reset seen at power-up
  logic ide_r; // latched mode, high for ide
  logic [2:0] ctrl_r; // control register
  logic irq_pend_r; // interrupt pending
  logic we_n_d_r; // write strobe one cycle back
  logic in_rst; // state is reset
  logic pc_sel; // pins read with pc card meaning
  logic host_rst; // host reset asserted, decoded
  logic mode_ide; // ide meaning in force
  logic mem_m; // pc card memory mode
  logic io_m; // pc card i/o mode
  logic init_go; // start initialisation timer
  logic init_busy; // initialisation running
  logic pulse_go; // start irq pulse
  logic pulse_busy; // irq pulse running
  logic hold_hi; // reset held since power-up
  logic init_done; // initialisation complete
  logic we_rise; // write strobe released
  logic irq_set; // interrupt event counts
  logic irq_clr; // software clears pending
  logic setup; // apb setup phase
  logic acc_wr; // apb write access taken
  logic hit_ctrl; // control address
  logic hit_stat; // status address
  logic [31:0] stat_w; // status word
  logic rdy_nxt; // next shared ready/irq pin
  logic wp_nxt; // next shared wp pin

  // mode decode: in reset the mode pin is still live, afterwards only
  // the latched copy counts, so a wandering pin cannot flip meanings
  assign in_rst = (st_r == card_pkg::ST_RESET);
  assign pc_sel = in_rst ? host.mode_sel : ~ide_r;
  assign mode_ide = ~pc_sel;
  assign io_m = pc_sel & ctrl_r[card_pkg::CTRL_IO];
  assign mem_m = pc_sel & ~ctrl_r[card_pkg::CTRL_IO];

  // reset pin polarity follows the mode; open counts as reset for pc card
  assign host_rst = pc_sel ? (host.rst_pin | host.rst_open)
                           : ~host.rst_pin;

  assign init_go = in_rst & ~host_rst;
  assign init_done = (st_r == card_pkg::ST_READY);
  assign hold_hi = in_rst & first_r & host_rst;

  // state sequencing: reset, then timed init, then ready
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      card_pkg::ST_RESET: begin
        if (!host_rst) begin
          st_nxt = card_pkg::ST_INIT;
        end
      end
      card_pkg::ST_INIT: begin
        if (host_rst) begin
          st_nxt = card_pkg::ST_RESET;
        end else if (!init_busy) begin
          st_nxt = card_pkg::ST_READY;
        end
      end
      card_pkg::ST_READY: begin
        if (host_rst) begin
          st_nxt = card_pkg::ST_RESET;
        end
      end
      default: begin
        st_nxt = card_pkg::ST_RESET; // illegal code recovers to reset
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= card_pkg::ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // power-up marker: cleared the first time the host reset is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_r <= 1'b1;
    end else if (init_go) begin
      first_r <= 1'b0;
    end
  end

  // mode latch: follows the pin only while in reset, frozen after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ide_r <= 1'b0;
    end else if (in_rst) begin
      ide_r <= ~host.mode_sel;
    end
  end

  // initialisation window timer
  cnt_timer #(
    .CYCLES(INIT_CYC)
  ) u_init_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .start(init_go),
    .busy(init_busy)
  );

  // irq pulse timer, only used in pulse mode
  cnt_timer #(
    .CYCLES(card_pkg::PULSE_CYC)
  ) u_pulse_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .start(pulse_go),
    .busy(pulse_busy)
  );

  assign pulse_go = core.irq_evt & io_m & ~ctrl_r[card_pkg::CTRL_LVL];

  // memory mode has no interrupt pin, so its events are dropped
  assign irq_set = core.irq_evt & ~mem_m & ~in_rst;

  // apb decode; the slave never waits, so access equals completion
  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pwrite & pready;
  assign hit_ctrl = (paddr == card_pkg::OFS_CTRL);
  assign hit_stat = (paddr == card_pkg::OFS_STAT);
  assign irq_clr = acc_wr & hit_stat & pwdata[card_pkg::STAT_IRQ];

  // pending interrupt: a set in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_r <= 1'b0;
    end else if (in_rst) begin
      irq_pend_r <= 1'b0; // a host reset drops any request
    end else if (irq_set) begin
      irq_pend_r <= 1'b1;
    end else if (irq_clr) begin
      irq_pend_r <= 1'b0;
    end
  end

  // control register; a host reset returns a pc card to memory mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= card_pkg::CTRL_RST;
    end else if (acc_wr & hit_ctrl) begin
      ctrl_r <= pwdata[2:0];
    end else if (in_rst) begin
      ctrl_r[card_pkg::CTRL_IO] <= 1'b0;
    end
  end

  // status word assembled from live state
  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[card_pkg::STAT_READY] = init_done & ~core.busy;
    stat_w[card_pkg::STAT_IDE] = ide_r;
    stat_w[card_pkg::STAT_IRQ] = irq_pend_r;
    stat_w[card_pkg::STAT_INIT] = init_done;
    stat_w[card_pkg::STAT_HOLD] = hold_hi;
  end

  // read data and error captured in setup so they stand in the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~(hit_ctrl | hit_stat); // unmapped: error, reads zero
      if (pwrite | ~(hit_ctrl | hit_stat)) begin
        prdata <= 32'h0000_0000;
      end else if (hit_ctrl) begin
        prdata <= {29'h0000_0000, ctrl_r};
      end else begin
        prdata <= stat_w;
      end
    end
  end

  // ready rises after reset and stays: zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // shared pin 37 meaning per mode
  always_comb begin
    if (mode_ide) begin
      rdy_nxt = irq_pend_r;
    end else if (io_m) begin
      rdy_nxt = ctrl_r[card_pkg::CTRL_LVL] ? ~irq_pend_r
                                           : ~pulse_busy;
    end else begin
      rdy_nxt = hold_hi | (init_done & ~core.busy);
    end
  end

  // shared pin 24 meaning per mode
  always_comb begin
    if (mode_ide) begin
      wp_nxt = ~core.word_xfer;
    end else if (io_m) begin
      wp_nxt = ~core.port16;
    end else begin
      wp_nxt = ~init_done;
    end
  end

  // pin flops; wait is never asserted so cycles are never stretched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins.rdy_irq <= 1'b0;
      pins.wait_n <= 1'b1;
      pins.wp <= 1'b1;
    end else begin
      pins.rdy_irq <= rdy_nxt;
      pins.wait_n <= 1'b1;
      pins.wp <= wp_nxt;
    end
  end

  // write strobe history, strobe acts on its release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_n_d_r <= 1'b1;
    end else begin
      we_n_d_r <= host.we_n;
    end
  end

  assign we_rise = host.we_n & ~we_n_d_r;

  // core strobes; ide mode ignores the write strobe altogether
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= '0;
    end else begin
      ctl.attr_sel <= mem_m & ~host.reg_n;
      ctl.mem_wr <= mem_m & we_rise & ~in_rst;
      ctl.cfg_wr <= io_m & we_rise & ~host.reg_n;
      ctl.dmack <= mode_ide & ctrl_r[card_pkg::CTRL_DMA]
                   & ~host.dmack_n;
      ctl.init_done <= init_done;
    end
  end

  // checks are armed one edge after reset release, so an attempt begun
  // on the releasing edge never judges the flops' reset values
  logic chk_en_r; // checks armed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_en_r <= 1'b0;
    end else begin
      chk_en_r <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !chk_en_r);

  a_wait_idle: assert property (
    ##1 pins.wait_n) else $error("wait pin asserted");

  a_busy_low: assert property (
    mem_m & init_done & core.busy |=> !pins.rdy_irq)
    else $error("ready high while busy");

  a_ready_high: assert property (
    mem_m & init_done & !core.busy |=> pins.rdy_irq)
    else $error("ready low while idle");

  a_init_low: assert property (
    mem_m & (st_r == card_pkg::ST_INIT) |=> !pins.rdy_irq)
    else $error("ready high during init");

  a_init_len: assert property (
    init_go ##1 !host_rst [*2] |-> !init_done)
    else $error("init ended too early");

  a_hold_high: assert property (
    mem_m & in_rst & first_r & host_rst |=> pins.rdy_irq)
    else $error("ready low in power-up reset");

  a_irq_level: assert property (
    io_m & ctrl_r[card_pkg::CTRL_LVL] & irq_pend_r |=> !pins.rdy_irq)
    else $error("level irq not held low");

  a_irq_pulse: assert property (
    pulse_go |=> ##1 !pins.rdy_irq [*1] ##0 $stable(ide_r))
    else $error("irq pulse missing");

  a_intrq_hi: assert property (
    mode_ide & irq_pend_r |=> pins.rdy_irq)
    else $error("intrq not high");

  a_attr_sel: assert property (
    mem_m & !host.reg_n |=> ctl.attr_sel)
    else $error("attribute space not selected");

  a_dmack_off: assert property (
    !ctrl_r[card_pkg::CTRL_DMA] |=> !ctl.dmack)
    else $error("dmack passed with dma off");

  a_pc_reset: assert property (
    init_done & !ide_r & host.rst_open |=> in_rst)
    else $error("open reset pin ignored");

  a_ide_reset: assert property (
    init_done & ide_r & !host.rst_pin |=> in_rst)
    else $error("ide reset ignored");

  a_cfg_only: assert property (
    ctl.cfg_wr |-> $past(io_m) & !$past(mode_ide))
    else $error("config write outside i/o mode");

  a_wp_low: assert property (
    mem_m & init_done |=> !pins.wp) else $error("wp not low");

  a_iois16: assert property (
    io_m |=> pins.wp == !$past(core.port16))
    else $error("port16 pin wrong");

  a_iocs16: assert property (
    mode_ide |=> pins.wp == !$past(core.word_xfer))
    else $error("cs16 pin wrong");

  a_mode_hold: assert property (
    !in_rst |=> $stable(ide_r)) else $error("mode changed out of reset");
endmodule // card_host_signal_control
`default_nettype wire

// file: sim/host_socket.sv
// host_socket: host side of the card connector control pins.
// assumes the bench calls its tasks; pins move just after pclk edges.
`timescale 1ns/10ps
`default_nettype none
module host_socket (
  input wire logic pclk, // bench clock
  output var card_pkg::host_pins_t host // pins to the card
);
  // idle: pc card mode, reset off, strobes high, no dma
  initial begin
    host = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  end
  // mode is set with power off and kept through reset
  task automatic power(input logic ide, input logic rst);
    host.mode_sel <= ~ide;
    host.rst_pin <= rst;
  endtask
  // reset pin level as the host drives it
  task automatic hreset(input logic lvl);
    @(posedge pclk);
    host.rst_pin <= lvl;
  endtask
  // unconnected reset pin, which pc card modes read as reset
  task automatic open_pin(input logic lvl);
    @(posedge pclk);
    host.rst_open <= lvl;
  endtask
  // dma acknowledge, also driven with dma mode off to see it blocked
  task automatic dmack(input logic lvl);
    @(posedge pclk);
    host.dmack_n <= lvl;
  endtask
  // write strobe; reg low for attribute or i/o; rude breaks the ide tie
  task automatic strobe(input logic rn, input logic rude);
    @(posedge pclk);
    host.reg_n <= rn;
    host.we_n <= ~(host.mode_sel | rude);
    @(posedge pclk);
    host.we_n <= 1'b1;
  endtask
endmodule // host_socket
`default_nettype wire

// file: sim/tb_top.sv
// tb_top: self-checking bench for the card control pin block.
// assumes host_socket stands in for the host; apb is driven here.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic pclk; // 10 MHz
  logic presetn; // power-up reset
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  card_pkg::host_pins_t host; // from the host model
  card_pkg::core_stat_t core; // card core status
  card_pkg::card_pins_t pins;
  card_pkg::core_ctl_t ctl;
  int errors = 0;
  int tests_run = 0;
  int n_mem = 0; // write strobe pulses seen
  int n_cfg = 0;
  logic [31:0] q;
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  host_socket hs (.pclk(pclk), .host(host));
  card_host_signal_control #(.INIT_TIME_US(1)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host(host), .core(core), .pins(pins), .ctl(ctl));
  // strobe pulses are counted in cycles so a stuck strobe shows
  always @(posedge pclk) begin
    n_mem += int'(ctl.mem_wr);
    n_cfg += int'(ctl.cfg_wr);
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer; waits for pready with a bound
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    chk("pready", pready, 1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  // settle n edges, then look between edges
  task automatic at(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic pu(input logic ide, input logic rst);
    @(posedge pclk);
    presetn <= 1'b0;
    hs.power(ide, rst);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // host keeps off the card until ready rises, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    while (pins.rdy_irq !== 1'b1 && n < 60) begin
      @(negedge pclk);
      n++;
    end
    chk("ready", pins.rdy_irq, 1);
  endtask
  task automatic irq_pulse();
    @(posedge pclk);
    core.irq_evt <= 1'b1;
    @(posedge pclk);
    core.irq_evt <= 1'b0;
  endtask
  task automatic t_mem();
    logic e;
    at(8);
    chk("rdy init", pins.rdy_irq, 0);
    chk("wp init", pins.wp, 1);
    wait_rdy();
    chk("wp", pins.wp, 0);
    chk("init out", ctl.init_done, 1);
    rd(card_pkg::OFS_STAT);
    chk("stat", q, 32'h00000009);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk("unmapped", {q[30:0], e}, 32'h00000001);
    @(posedge pclk);
    core.busy <= 1'b1;
    at(3);
    chk("busy", pins.rdy_irq, 0);
    @(posedge pclk);
    core.busy <= 1'b0;
    at(3);
    chk("idle", pins.rdy_irq, 1);
    n_mem = 0;
    hs.strobe(1'b0, 1'b0);
    at(3);
    chk("attr", ctl.attr_sel, 1);
    hs.strobe(1'b1, 1'b0);
    at(3);
    chk("common", ctl.attr_sel, 0);
    chk("mem_wr", n_mem, 2);
    chk("wait", pins.wait_n, 1);
  endtask
  task automatic t_hold();
    pu(1'b0, 1'b1);
    at(5);
    chk("held rdy", pins.rdy_irq, 1);
    rd(card_pkg::OFS_STAT);
    chk("held", q[4], 1);
    hs.hreset(1'b0);
    at(4);
    chk("rdy rel", pins.rdy_irq, 0);
    wait_rdy();
    hs.hreset(1'b1);
    at(3);
    chk("rdy rst", pins.rdy_irq, 0);
    hs.hreset(1'b0);
    wait_rdy();
    hs.open_pin(1'b1);
    at(3);
    chk("rdy open", pins.rdy_irq, 0);
    hs.open_pin(1'b0);
    wait_rdy();
  endtask
  task automatic t_io();
    int lo;
    lo = 0;
    wr(card_pkg::OFS_CTRL, 32'h1);
    irq_pulse();
    repeat (10) begin
      @(negedge pclk);
      lo += int'(!pins.rdy_irq);
    end
    chk("pulse", lo, card_pkg::PULSE_CYC);
    rd(card_pkg::OFS_CTRL);
    chk("ctrl", q, 32'h00000001);
    wr(card_pkg::OFS_STAT, 32'h4);
    wr(card_pkg::OFS_CTRL, 32'h3);
    at(2);
    chk("level idle", pins.rdy_irq, 1);
    irq_pulse();
    at(12);
    chk("level", pins.rdy_irq, 0);
    wr(card_pkg::OFS_STAT, 32'h4);
    at(2);
    chk("cleared", pins.rdy_irq, 1);
    @(posedge pclk);
    core.port16 <= 1'b1;
    at(3);
    chk("io16", pins.wp, 0);
    @(posedge pclk);
    core.port16 <= 1'b0;
    at(3);
    chk("io8", pins.wp, 1);
    n_mem = 0;
    n_cfg = 0;
    hs.strobe(1'b0, 1'b0);
    at(3);
    chk("cfg", {n_cfg[15:0], n_mem[15:0]}, 32'h00010000);
  endtask
  task automatic t_ide();
    pu(1'b1, 1'b1);
    at(20);
    rd(card_pkg::OFS_STAT);
    chk("ide", q[3:1], 3'b101);
    hs.hreset(1'b0);
    at(3);
    rd(card_pkg::OFS_STAT);
    chk("ide rst", q[3:1], 3'b001);
    hs.hreset(1'b1);
    irq_pulse();
    at(20);
    chk("intrq", pins.rdy_irq, 1);
    wr(card_pkg::OFS_STAT, 32'h4);
    at(2);
    chk("intrq off", pins.rdy_irq, 0);
    @(posedge pclk);
    core.word_xfer <= 1'b1;
    at(3);
    chk("cs16", pins.wp, 0);
    hs.dmack(1'b0);
    at(3);
    chk("dmack off", ctl.dmack, 0);
    wr(card_pkg::OFS_CTRL, 32'h4);
    at(3);
    chk("dmack", ctl.dmack, 1);
    n_mem = 0;
    n_cfg = 0;
    hs.strobe(1'b0, 1'b1);
    at(3);
    chk("ide we", n_mem + n_cfg, 0);
    chk("iordy", pins.wait_n, 1);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    core = '0;
    pu(1'b0, 1'b0);
    t_mem();
    t_io();
    t_hold();
    t_ide();
    conclude();
  end
  // the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
